// ===== src/spi_dg_pkg.sv
// Shared constants and types for the 40-bit serial datagram port
package spi_dg_pkg;

  // ----------------------------------------------------------------
  // Datagram layout
  // ----------------------------------------------------------------
  localparam int DG_BITS  = 40;
  localparam int DATA_W   = 32;
  localparam int ADDR_W   = 7;
  localparam int CNT_W    = 6;
  localparam int WR_BIT   = 39;
  localparam int ADDR_MSB = 38;
  localparam int ADDR_LSB = 32;
  localparam int STAT_MSB = 39;
  localparam int STAT_LSB = 32;

  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 6'h27;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h28;

  localparam logic [7:0]        WRITE_OFFSET       = 8'h80;
  localparam logic [ADDR_W-1:0] GLOBAL_STATUS_ADDR = 7'h01;

  // ----------------------------------------------------------------
  // Source bit positions of the status byte
  // ----------------------------------------------------------------
  localparam int RAMP_STOP_R_BIT  = 1;
  localparam int RAMP_STOP_L_BIT  = 0;
  localparam int RAMP_POS_BIT     = 9;
  localparam int RAMP_VEL_BIT     = 8;
  localparam int DRV_STILL_BIT    = 31;
  localparam int DRV_STALL_BIT    = 24;
  localparam int GST_DRV_ERR_BIT  = 1;
  localparam int GST_RESET_BIT    = 0;

  // ----------------------------------------------------------------
  // Timing of the host end
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 8;
  localparam int SCK_HALF_NS   = 48;
  localparam int SEL_GAP_NS    = 128;
  localparam int HALF_CYC = (SCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int GAP_CYC  = (SEL_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int DIV_W    = 8;
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYC - 1);
  localparam logic [DIV_W-1:0] GAP_LAST  = DIV_W'(GAP_CYC - 1);

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    D_IDLE = 1'b0,
    D_LOAD = 1'b1
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_LOW  = 3'b010,
    H_HIGH = 3'b011,
    H_TAIL = 3'b100,
    H_GAP  = 3'b101
  } host_state_t;

endpackage : spi_dg_pkg

// ===== src/spi_dg_if.sv
// Four-wire serial link between host end and device end
`timescale 1ns/1ps
interface spi_dg_if;
  logic sclk;
  logic select_line_low;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // Undriven output floats high as with a pull-up
  assign miso_line = miso_oe ? miso : 1'b1;

  modport host (
    output sclk,
    output select_line_low,
    output mosi,
    input  miso_line
  );

  modport device (
    input  sclk,
    input  select_line_low,
    input  mosi,
    output miso,
    output miso_oe
  );
endinterface : spi_dg_if

// ===== src/shift_sync.sv
// Three-stage input synchroniser with filtered level and edge pulses
`timescale 1ns/1ps
module shift_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
    logic       rise;
    logic       fall;
  } sync_st_t;

  sync_st_t s_r;
  sync_st_t s_nxt;

  // Stage 0 feeds only stage 1; decisions look at stages 1 and 2
  always_comb begin
    s_nxt      = s_r;
    s_nxt.sh   = {s_r.sh[1:0], async_in};
    if (s_r.sh[1] == s_r.sh[2]) begin
      s_nxt.lvl = s_r.sh[2];
    end
    s_nxt.rise = s_nxt.lvl & ~s_r.lvl;
    s_nxt.fall = ~s_nxt.lvl & s_r.lvl;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{sh: {3{RST_VAL}}, lvl: RST_VAL, rise: 1'b0, fall: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.lvl;
  assign rise  = s_r.rise;
  assign fall  = s_r.fall;

endmodule : shift_sync

// ===== src/dg_target.sv
// Device end of the 40-bit datagram port: shifter on the link clock, user side on the system clock
`timescale 1ns/1ps
module dg_target (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  spi_dg_if.device                           link,
  output logic                               req_valid,
  output logic                               req_write,
  output logic [spi_dg_pkg::ADDR_W-1:0]      req_addr,
  output logic [spi_dg_pkg::DATA_W-1:0]      req_wdata,
  input  wire logic [spi_dg_pkg::DATA_W-1:0] rd_data,
  input  wire logic [31:0]                   ramp_status_reg,
  input  wire logic [31:0]                   driver_status_reg,
  input  wire logic [31:0]                   global_status_reg,
  output logic                               clear_global_status,
  output logic                               frame_short,
  output logic                               link_busy
);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [spi_dg_pkg::DG_BITS-1:0] shreg;
    logic                           got_full;
  } shift_st_t;

  typedef struct packed {
    logic drive;
    logic oe;
  } out_st_t;

  typedef struct packed {
    spi_dg_pkg::dev_state_t         state;
    logic                           req_valid;
    logic                           req_write;
    logic [spi_dg_pkg::ADDR_W-1:0]  req_addr;
    logic [spi_dg_pkg::DATA_W-1:0]  req_wdata;
    logic                           clr_gst;
    logic                           short_p;
    logic                           busy;
    logic [spi_dg_pkg::DG_BITS-1:0] resp;
  } sys_st_t;

  logic [spi_dg_pkg::CNT_W-1:0] cnt_r;
  logic [spi_dg_pkg::CNT_W-1:0] cnt_nxt;
  shift_st_t                    sh_r;
  shift_st_t                    sh_nxt;
  out_st_t                      out_r;
  out_st_t                      out_nxt;
  sys_st_t                      sys_r;
  sys_st_t                      sys_nxt;
  logic [spi_dg_pkg::DG_BITS-1:0] cur_word;
  logic [7:0]                   status_byte;
  logic                         frame_rst_n;
  logic                         sel_level;
  logic                         sel_release;

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  // Bit counter lives only inside a frame: a released select clears it
  // at once, since the link clock is quiet between frames.  The
  // select pin acts as a reset here, so it must be glitch free.
  assign frame_rst_n = rst_n & ~link.select_line_low;

  always_comb begin
    if (cnt_r == spi_dg_pkg::CNT_FULL) begin
      cnt_nxt = cnt_r;
    end else begin
      cnt_nxt = cnt_r + 6'h01;
    end
  end

  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_r <= spi_dg_pkg::CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Response word enters the shifter on the first edge of a frame
  always_comb begin
    if (cnt_r == spi_dg_pkg::CNT_ZERO) begin
      cur_word = sys_r.resp;
    end else begin
      cur_word = sh_r.shreg;
    end
  end

  // One 40-bit register both returns the response and collects the
  // command, so surplus bits fall out after exactly 40 clocks.
  always_comb begin
    sh_nxt       = sh_r;
    sh_nxt.shreg = {cur_word[spi_dg_pkg::DG_BITS-2:0], link.mosi};
    sh_nxt.got_full = (cnt_r == spi_dg_pkg::CNT_LAST) |
                      ((cnt_r != spi_dg_pkg::CNT_ZERO) & sh_r.got_full);
  end

  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= '0;
    end else begin
      sh_r <= sh_nxt;
    end
  end

  always_comb begin
    out_nxt    = out_r;
    out_nxt.oe = 1'b1;
    if (cnt_r == spi_dg_pkg::CNT_ZERO) begin
      out_nxt.drive = sys_r.resp[spi_dg_pkg::DG_BITS-1];
    end else begin
      out_nxt.drive = sh_r.shreg[spi_dg_pkg::DG_BITS-1];
    end
  end

  // Output moves on the falling edge, half a period ahead of sampling
  always_ff @(negedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign link.miso    = out_r.drive;
  assign link.miso_oe = out_r.oe;

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  shift_sync #(
    .RST_VAL (1'b1)
  ) u_sel_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (link.select_line_low),
    .level    (sel_level),
    .rise     (sel_release),
    .fall     ()
  );

  assign status_byte = {
    ramp_status_reg[spi_dg_pkg::RAMP_STOP_R_BIT],
    ramp_status_reg[spi_dg_pkg::RAMP_STOP_L_BIT],
    ramp_status_reg[spi_dg_pkg::RAMP_POS_BIT],
    ramp_status_reg[spi_dg_pkg::RAMP_VEL_BIT],
    driver_status_reg[spi_dg_pkg::DRV_STILL_BIT],
    driver_status_reg[spi_dg_pkg::DRV_STALL_BIT],
    global_status_reg[spi_dg_pkg::GST_DRV_ERR_BIT],
    global_status_reg[spi_dg_pkg::GST_RESET_BIT]
  };

  // The shifter and its full flag are read here only after the
  // select release has passed the synchroniser; the link clock is
  // still by then, so the word is static while it is taken over.
  always_comb begin
    sys_nxt           = sys_r;
    sys_nxt.req_valid = 1'b0;
    sys_nxt.clr_gst   = 1'b0;
    sys_nxt.short_p   = 1'b0;
    sys_nxt.busy      = ~sel_level;
    case (sys_r.state)
      spi_dg_pkg::D_IDLE: begin
        if (sel_release) begin
          if (sh_r.got_full) begin
            sys_nxt.req_valid = 1'b1;
            sys_nxt.req_write = sh_r.shreg[spi_dg_pkg::WR_BIT];
            sys_nxt.req_addr  =
              sh_r.shreg[spi_dg_pkg::ADDR_MSB:spi_dg_pkg::ADDR_LSB];
            sys_nxt.req_wdata = sh_r.shreg[spi_dg_pkg::DATA_W-1:0];
            sys_nxt.state     = spi_dg_pkg::D_LOAD;
          end else begin
            sys_nxt.short_p = 1'b1;
          end
        end
      end
      spi_dg_pkg::D_LOAD: begin
        // Snapshot taken before the clear pulse reaches the flags
        sys_nxt.resp[spi_dg_pkg::STAT_MSB:spi_dg_pkg::STAT_LSB] =
          status_byte;
        if (sys_r.req_write) begin
          sys_nxt.resp[spi_dg_pkg::DATA_W-1:0] = sys_r.req_wdata;
        end else begin
          sys_nxt.resp[spi_dg_pkg::DATA_W-1:0] = rd_data;
        end
        sys_nxt.clr_gst = ~sys_r.req_write &
          (sys_r.req_addr == spi_dg_pkg::GLOBAL_STATUS_ADDR);
        sys_nxt.state = spi_dg_pkg::D_IDLE;
      end
      default: begin
        sys_nxt.state = spi_dg_pkg::D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_r       <= '0;
      sys_r.state <= spi_dg_pkg::D_IDLE;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  // ----------------------------------------------------------------
  // User side outputs
  // ----------------------------------------------------------------
  // Reads pass the address and also the data field on req_wdata; req_write low keeps registers
  // untouched, which the user side must honour.
  assign req_valid           = sys_r.req_valid;
  assign req_write           = sys_r.req_write;
  assign req_addr            = sys_r.req_addr;
  assign req_wdata           = sys_r.req_wdata;
  assign clear_global_status = sys_r.clr_gst;
  assign frame_short         = sys_r.short_p;
  assign link_busy           = sys_r.busy;

endmodule : dg_target

// ===== src/dg_host.sv
// Host end: forms datagrams, makes the link clock, returns responses
`timescale 1ns/1ps
module dg_host (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  spi_dg_if.host                             link,
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_write,
  input  wire logic [spi_dg_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [spi_dg_pkg::DATA_W-1:0] cmd_wdata,
  output logic                               cmd_ready,
  output logic                               resp_valid,
  output logic [7:0]                         resp_status,
  output logic [spi_dg_pkg::DATA_W-1:0]      resp_data
);

  typedef struct packed {
    spi_dg_pkg::host_state_t        state;
    logic [spi_dg_pkg::DIV_W-1:0]   div;
    logic [spi_dg_pkg::CNT_W-1:0]   bits;
    logic [spi_dg_pkg::DG_BITS-1:0] tx;
    logic [spi_dg_pkg::DG_BITS-1:0] rx;
    logic                           sck;
    logic                           sel_n;
    logic                           mosi;
    logic                           ready;
    logic                           rvalid;
  } host_st_t;

  host_st_t   s_r;
  host_st_t   s_nxt;
  logic       miso_s;
  logic [7:0] addr_byte;

  // ----------------------------------------------------------------
  // Return line synchroniser
  // ----------------------------------------------------------------
  shift_sync #(
    .RST_VAL (1'b1)
  ) u_miso_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (link.miso_line),
    .level    (miso_s),
    .rise     (),
    .fall     ()
  );

  always_comb begin
    if (cmd_write) begin
      addr_byte = {1'b0, cmd_addr} + spi_dg_pkg::WRITE_OFFSET;
    end else begin
      addr_byte = {1'b0, cmd_addr};
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Half period is long enough to cover the synchroniser delay on the
  // return line, so the bit seen at the rising edge is settled.
  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.div    = s_r.div + 8'h01;
    case (s_r.state)
      spi_dg_pkg::H_IDLE: begin
        s_nxt.div = '0;
        if (cmd_valid && s_r.ready) begin
          s_nxt.tx    = {addr_byte,
                         cmd_write ? cmd_wdata : 32'h0000_0000};
          s_nxt.bits  = spi_dg_pkg::CNT_ZERO;
          s_nxt.sel_n = 1'b0;
          s_nxt.ready = 1'b0;
          s_nxt.state = spi_dg_pkg::H_LEAD;
        end
      end
      spi_dg_pkg::H_LEAD, spi_dg_pkg::H_HIGH: begin
        if (s_r.div == spi_dg_pkg::HALF_LAST) begin
          s_nxt.div = '0;
          if (s_r.bits == spi_dg_pkg::CNT_FULL) begin
            s_nxt.state = spi_dg_pkg::H_TAIL;
          end else begin
            s_nxt.sck   = 1'b0;
            s_nxt.mosi  = s_r.tx[spi_dg_pkg::DG_BITS-1];
            s_nxt.tx    = {s_r.tx[spi_dg_pkg::DG_BITS-2:0], 1'b0};
            s_nxt.state = spi_dg_pkg::H_LOW;
          end
        end
      end
      spi_dg_pkg::H_LOW: begin
        if (s_r.div == spi_dg_pkg::HALF_LAST) begin
          s_nxt.div   = '0;
          s_nxt.sck   = 1'b1;
          s_nxt.rx    = {s_r.rx[spi_dg_pkg::DG_BITS-2:0], miso_s};
          s_nxt.bits  = s_r.bits + 6'h01;
          s_nxt.state = spi_dg_pkg::H_HIGH;
        end
      end
      spi_dg_pkg::H_TAIL: begin
        if (s_r.div == spi_dg_pkg::HALF_LAST) begin
          s_nxt.div   = '0;
          s_nxt.sel_n = 1'b1;
          s_nxt.state = spi_dg_pkg::H_GAP;
        end
      end
      spi_dg_pkg::H_GAP: begin
        if (s_r.div == spi_dg_pkg::GAP_LAST) begin
          s_nxt.rvalid = 1'b1;
          s_nxt.ready  = 1'b1;
          s_nxt.state  = spi_dg_pkg::H_IDLE;
        end
      end
      default: begin
        s_nxt.state = spi_dg_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.state <= spi_dg_pkg::H_IDLE;
      s_r.sck   <= 1'b1;
      s_r.sel_n <= 1'b1;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.sclk            = s_r.sck;
  assign link.select_line_low = s_r.sel_n;
  assign link.mosi            = s_r.mosi;
  assign cmd_ready            = s_r.ready;
  assign resp_valid           = s_r.rvalid;
  assign resp_status = s_r.rx[spi_dg_pkg::STAT_MSB:spi_dg_pkg::STAT_LSB];
  assign resp_data            = s_r.rx[spi_dg_pkg::DATA_W-1:0];

endmodule : dg_host

// ===== tb/dg_link_monitor.sv
// Concurrent checks on the serial link between the two design ends
`timescale 1ns/1ps
module dg_link_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic select_line_low,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  // ----------------------------------------------------------------
  // Helper: rising link-clock edges seen in the current frame
  // ----------------------------------------------------------------
  logic       sclk_q_r;
  logic [6:0] rises_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_r <= 1'b1;
      rises_r  <= 7'h00;
    end else begin
      sclk_q_r <= sclk;
      if (select_line_low) begin
        rises_r <= 7'h00;
      end else if (sclk && !sclk_q_r) begin
        rises_r <= rises_r + 7'h01;
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_idle_high;
    select_line_low |-> sclk;
  endproperty
  property p_lead;
    $fell(select_line_low) |-> sclk [*6] ##1 !sclk;
  endproperty
  property p_low_half;
    $fell(sclk) |-> !sclk [*6] ##1 sclk;
  endproperty
  property p_mosi_on_fall;
    $changed(mosi) |-> $fell(sclk) || select_line_low;
  endproperty
  property p_miso_on_fall;
    miso_oe && $past(miso_oe) && $changed(miso) |-> $fell(sclk);
  endproperty
  property p_oe_in_frame;
    $fell(sclk) |-> miso_oe;
  endproperty
  property p_oe_idle;
    select_line_low && $past(select_line_low) |-> !miso_oe && miso_line;
  endproperty
  property p_count40;
    $rose(select_line_low) |-> rises_r == 7'h28;
  endproperty
  property p_sel_hold;
    $fell(sclk) |-> !select_line_low [*7];
  endproperty
  property p_gap;
    $rose(select_line_low) |-> select_line_low [*8];
  endproperty

  a_idle_high: assert property (p_idle_high)
    else $error("link clock low while deselected");
  a_lead: assert property (p_lead)
    else $error("select lead time wrong");
  a_low_half: assert property (p_low_half)
    else $error("link clock low phase wrong");
  a_mosi_on_fall: assert property (p_mosi_on_fall)
    else $error("host data changed away from falling edge");
  a_miso_on_fall: assert property (p_miso_on_fall)
    else $error("device data changed away from falling edge");
  a_oe_in_frame: assert property (p_oe_in_frame)
    else $error("device not driving during frame");
  a_oe_idle: assert property (p_oe_idle)
    else $error("device drives while deselected");
  a_count40: assert property (p_count40)
    else $error("frame not forty clocks");
  a_sel_hold: assert property (p_sel_hold)
    else $error("select released inside frame");
  a_gap: assert property (p_gap)
    else $error("select high time too short");

  c_frame_end: cover property ($rose(select_line_low));
  c_mosi_one: cover property ($fell(sclk) && mosi);
  c_miso_move: cover property (miso_oe && $changed(miso));
endmodule : dg_link_monitor

// ===== tb/stepper_spi_datagram_port_tb.sv
// Testbench: host end against device end, plus a bench-driven link
`timescale 1ns/1ps
module stepper_spi_datagram_port_tb;
  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic [6:0]  cmd_addr  = 7'h00;
  logic [31:0] cmd_wdata = 32'h0;
  logic [31:0] ramp      = 32'h0;
  logic [31:0] drv       = 32'h0;
  logic [31:0] gst       = 32'h0;
  logic        cmd_ready, resp_valid, req_valid, req_write, clear_gst;
  logic [7:0]  resp_status;
  logic [31:0] resp_data, req_wdata, rd_data, req_wdata_b, rd_data_b;
  logic [6:0]  req_addr, req_addr_b;
  logic        req_valid_b, req_write_b, frame_short_b;
  logic [31:0] regs [0:127];
  logic [39:0] rsp;
  logic [63:0] rx;
  int          miscompares = 0;
  int          n_compared  = 0;
  int          n_clear     = 0;
  int          n_short_b   = 0;
  int          n_req_b     = 0;
  int          n_short_a   = 0;
  logic        busy_b, short_a;

  spi_dg_if link1 ();
  spi_dg_if link2 ();

  always #4 clk_sys = ~clk_sys;

  assign rd_data   = (req_addr == 7'h01) ? gst : regs[req_addr];
  assign rd_data_b = regs[req_addr_b];

  // ----------------------------------------------------------------
  // User side of the device ends: register file and flag clearing
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (req_valid && req_write) regs[req_addr] <= req_wdata;
    if (clear_gst) begin
      gst[1:0] <= 2'b00;
      n_clear++;
    end
    if (frame_short_b) n_short_b++;
    if (req_valid_b) n_req_b++;
    if (short_a) n_short_a++;
  end

  dg_host dg_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link1),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
    .resp_status(resp_status), .resp_data(resp_data));

  dg_target dg_target_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link1),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_data(rd_data), .ramp_status_reg(ramp),
    .driver_status_reg(drv), .global_status_reg(gst),
    .clear_global_status(clear_gst), .frame_short(short_a), .link_busy());

  // Second device end, driven by the bench to break frame lengths
  dg_target dg_target_fault_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link2), .req_valid(req_valid_b), .req_write(req_write_b),
    .req_addr(req_addr_b), .req_wdata(req_wdata_b), .rd_data(rd_data_b),
    .ramp_status_reg(ramp), .driver_status_reg(drv),
    .global_status_reg(gst), .clear_global_status(),
    .frame_short(frame_short_b), .link_busy(busy_b));

  dg_link_monitor dg_link_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .sclk(link1.sclk), .select_line_low(link1.select_line_low),
    .mosi(link1.mosi), .miso(link1.miso), .miso_oe(link1.miso_oe),
    .miso_line(link1.miso_line));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One host command; returns at the falling edge of the response cycle
  task automatic xfer(input logic w, input logic [6:0] a,
                      input logic [31:0] d);
    int i;
    cmd_write = w;
    cmd_addr  = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 8) begin
      @(negedge clk_sys);
      i++;
    end
    if (cmd_ready !== 1'b1) begin
      miscompares++;
      summarize();
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    while (resp_valid !== 1'b1 && i < 600) begin
      @(negedge clk_sys);
      i++;
    end
    if (i >= 600) begin
      miscompares++;
      summarize();
    end
    rsp = {resp_status, resp_data};
  endtask : xfer

  task automatic ck(input logic w, input logic [6:0] a,
                    input logic [31:0] d, input logic [39:0] exp);
    xfer(w, a, d);
    chk({24'h0, rsp}, {24'h0, exp});
  endtask : ck

  // Bit-banged frame of n bits, link clock period 32 ns, idle high
  task automatic bang(input int n, input logic [63:0] tx);
    rx = 64'h0;
    #3;
    link2.select_line_low = 1'b0;
    #16;
    for (int k = n - 1; k >= 0; k--) begin
      link2.sclk = 1'b0;
      link2.mosi = tx[k];
      #16;
      rx = {rx[62:0], link2.miso_line};
      link2.sclk = 1'b1;
      #16;
    end
    chk(64'(busy_b), 64'h1);
    #16;
    link2.select_line_low = 1'b1;
    link2.mosi = ~link2.mosi;
    repeat (24) @(negedge clk_sys);
    chk(64'(busy_b), 64'h0);
  endtask : bang

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    link2.sclk = 1'b1;
    link2.select_line_low = 1'b1;
    link2.mosi = 1'b0;
    for (int k = 0; k < 128; k++) regs[k] = 32'hC0DE0000 + 32'(k);
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    ck(1'b0, 7'h21, 32'h0, 40'h0);
    ck(1'b0, 7'h21, 32'hFFFFFFFF, {8'h00, regs[7'h21]});
    ck(1'b1, 7'h27, 32'h00ABCDEF, {8'h00, regs[7'h21]});
    ck(1'b1, 7'h27, 32'h00123456, 40'h0000ABCDEF);
    ck(1'b0, 7'h27, 32'h0, 40'h0000123456);
    chk({32'h0, regs[7'h27]}, 64'h00123456);
    chk({32'h0, regs[7'h21]}, 64'hC0DE0021);
    ck(1'b0, 7'h10, 32'h0, 40'h0000123456);
    for (int b = 0; b < 8; b++) begin
      ramp = 32'hFFFFFCFC;
      drv  = 32'h7EFFFFFF;
      gst  = 32'hFFFFFFFC;
      case (b)
        0: gst[0] = 1'b1;
        1: gst[1] = 1'b1;
        2: drv[24] = 1'b1;
        3: drv[31] = 1'b1;
        4: ramp[8] = 1'b1;
        5: ramp[9] = 1'b1;
        6: ramp[0] = 1'b1;
        default: ramp[1] = 1'b1;
      endcase
      xfer(1'b0, 7'h10, 32'h0);
      ck(1'b0, 7'h10, 32'h0, {8'h01 << b, regs[7'h10]});
    end
    ramp = 32'h0;
    drv  = 32'h0;
    gst  = 32'h3;
    xfer(1'b0, 7'h10, 32'h0);
    ck(1'b0, 7'h01, 32'h0, {8'h03, regs[7'h10]});
    ck(1'b0, 7'h10, 32'h0, 40'h0300000003);
    ck(1'b0, 7'h10, 32'h0, {8'h00, regs[7'h10]});
    chk(64'(n_clear), 64'h1);
    bang(40, {24'h0, 8'h85, 32'h13579BDF});
    chk(rx, 64'h0);
    chk({24'h0, req_write_b, req_addr_b, req_wdata_b}, 64'h8513579BDF);
    bang(20, 64'hFFFFF);
    chk({32'(n_short_b), 32'(n_req_b)}, 64'h0000000100000001);
    bang(48, {16'h0, 8'h5A, 8'h06, 32'h0});
    chk(rx, 64'h0000_0013_579B_DF5A);
    chk({56'h0, req_write_b, req_addr_b}, 64'h06);
    chk(64'(n_req_b), 64'h2);
    chk(64'(n_short_a), 64'h0);
    summarize();
  end
endmodule : stepper_spi_datagram_port_tb
